/* File: hw/ufc_defines.svh */
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH

// register indices (printed offsets); byte address = index * 4
`define UFC_IDX_FRAME        8'h07
`define UFC_IDX_BAUD_LO      8'h08
`define UFC_IDX_BAUD_HI      8'h09
`define UFC_IDX_ABWIN        8'h0a
`define UFC_IDX_DBG          8'h0b
`define UFC_IDX_INFRARED_EVENT_CONTROL       8'h0c
`define UFC_IDX_TXPW         8'h0d
`define UFC_IDX_RXFL         8'h0e
`define UFC_IDX_STATUS       8'h10

// field positions
`define UFC_MODE_HI          7
`define UFC_MODE_LO          6
`define UFC_PAR_HI           5
`define UFC_PAR_LO           4
`define UFC_STOP_BIT         3
`define UFC_CHW_HI           2
`define UFC_CHW_LO           0
`define UFC_ORDER_BIT        2
`define UFC_PHASE_BIT        1

// reset values
`define UFC_FRAME_RST        8'h03
`define UFC_SPI_RST          8'h00
`define UFC_BAUD_RST         16'h0000
`define UFC_BYTE_RST         8'h00

// pulse shaping constants
`define UFC_TXPW_THIRDS      8'h00
`define UFC_TXPW_BYPASS      8'hff
`define UFC_PW_NUM           3
`define UFC_PW_DEN           16

`endif

/* File: hw/ufc_pkg.sv */
package ufc_pkg;
  typedef enum logic [1:0] {
    UFC_ASYNC,
    UFC_SYNC,
    UFC_INFRARED_MODE,
    UFC_SPI_MASTER_MODE
  } ufc_mode_t;

  typedef enum logic [1:0] {
    UFC_PAR_OFF,
    UFC_PAR_RSVD,
    UFC_PAR_EVEN,
    UFC_PAR_ODD
  } ufc_parity_t;

  typedef enum logic [1:0] {
    UFC_TOL_18,
    UFC_TOL_15,
    UFC_TOL_21,
    UFC_TOL_25
  } ufc_tol_t;

  typedef enum logic [1:0] {
    UFC_RXM_NORMAL,
    UFC_RXM_CLK2X,
    UFC_RXM_GENERIC_AUTOBAUD,
    UFC_RXM_CONSTRAINED_AUTOBAUD
  } ufc_rxmode_t;
endpackage

/* File: hw/ufc_rx_filter.sv */
`timescale 1ns/1ps
// accepts a new line level only after len+1 equal consecutive samples
module ufc_rx_filter #(
  parameter int LEN_W = 7
) (
  input  wire logic             sys_clk,   // clock
  input  wire logic             rst_n,     // sync reset
  input  wire logic             enable,    // filter active
  input  wire logic [LEN_W-1:0] len,       // filter length, 0 = bypass
  input  wire logic             din,       // raw level
  output logic                  dout       // filtered level
);
  if (LEN_W < 1 || LEN_W > 16) begin
    $error("ufc_rx_filter: LEN_W out of range");
  end

  logic [LEN_W:0] run;
  logic           held;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run  <= '0;
      held <= 1'b1;
    end else if (din == held) begin
      run <= '0;
    end else if (run >= {1'b0, len}) begin
      held <= din;                                 // [R18]
      run  <= '0;
    end else begin
      run <= run + 1'b1;
    end
  end

  assign dout = (enable && len != '0) ? held : din;  // [R18]
endmodule

/* File: hw/ufc_frame_cfg.sv */
`timescale 1ns/1ps
`include "ufc_defines.svh"
// What this block does
// R1: two-bit mode field picks async, sync, infrared or master SPI.
// R2: mode 3 switches frame register to SPI layout: order and phase only.
// R3: parity field: off, reserved, even, odd; transmitter appends parity bit.
// R4: receiver checks parity over data bits and raises parity error.
// R5: stop-bit bit gives one or two transmit stop bits; receiver ignores it.
// R6: width field codes 5..8 bits, two reserved, two nine-bit orders.
// R7: SPI bit order: msb first when clear; software must not change mid-transfer.
// R8: SPI phase bit picks leading or trailing clock edge sampling.
// R9: 16-bit divisor, low byte at base, high byte at base plus one.
// R10: divisor write reloads the prescaler at once.
// R11: window field sets sync tolerance 18, 15, 21 or 25 percent.
// R12: debug-run clear halts port in break debug; set keeps running.
// R13: event input enable feeds infrared receiver and cuts receive pin.
// R14: pulse width zero gives three-sixteenths of baud period pulses.
// R15: other widths give that many clocks, starting on baud clock rise.
// R16: width all-ones passes signals through uncoded.
// R17: software sets pulse width before enabling transmitter; infrared only.
// R18: filter length zero bypasses; else value plus one samples needed.
// R19: software sets filter length before enabling receiver; infrared only.
// R20: auto-baud modes only honoured in asynchronous slave operation.
module ufc_frame_cfg #(
  parameter int RXFL_W = 7
) (
  input  wire logic        sys_clk,           // 20 MHz clock
  input  wire logic        rst_n,             // sync reset, active low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb direction
  input  wire logic [11:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  input  wire logic [3:0]  pstrb,             // apb byte strobes
  output logic             pready,            // apb ready
  output logic [31:0]      prdata,            // apb read data
  output logic             pslverr,           // apb error
  input  wire logic        dbg_halted,        // cpu in break debug
  input  wire logic        transmitter_on,    // tx enable from control b
  input  wire logic        receiver_on,       // rx enable from control b
  input  wire logic [1:0]  rx_mode,           // receiver mode from control b
  input  wire logic        xck_is_input,      // slave clocking selected
  input  wire logic        baud_tick,         // baud clock rising edge
  input  wire logic        tx_serial,         // raw tx line from shifter
  input  wire logic        rx_pin,            // receive pin
  input  wire logic        ir_event,          // infrared event source
  input  wire logic [8:0]  rx_data,           // received data bits
  input  wire logic        rx_parity_bit,     // received parity bit
  input  wire logic        rx_frame_done,     // pulse: frame received
  input  wire logic        parity_clear,      // pulse: clear parity error
  input  wire logic [8:0]  tx_data,           // data to transmit
  output logic             parity_error_flag, // sticky parity error
  output logic             tx_parity_bit,     // parity to append
  output logic             parity_en,         // parity appended
  output logic [1:0]       tx_stop_bits,      // 1 or 2 stop bits
  output logic [3:0]       data_bits,         // 5..9 data bits
  output logic             nine_bit_low_first,  // nine-bit low byte first
  output logic             nine_bit_high_first, // nine-bit high byte first
  output logic             spi_master_mode,   // master spi active
  output logic             infrared_mode,     // infrared active
  output logic             spi_lsb_first,     // spi bit order
  output logic             spi_trailing,      // spi trailing-edge sampling
  output logic [15:0]      baud_divisor,      // divisor value
  output logic             baud_reload,       // pulse: reload prescaler
  output logic [1:0]       sync_tol,          // tolerance code
  output logic             autobaud_allowed,  // generic/constrained usable
  output logic             port_run,          // low when halted with debug-run clear
  output logic             ir_tx_out,         // coded tx line
  output logic             ir_rx_in           // filtered rx line to receiver
);
  if (RXFL_W != 7) begin
    $error("ufc_frame_cfg: RXFL_W must be 7");
  end

  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0]        frame_format_control;
  logic [7:0]        spi_master_control;
  logic [15:0]       bit_rate_divisor;
  logic [7:0]        autobaud_window_control;
  logic [7:0]        debug_halt_control;
  logic [7:0]        infrared_event_control;
  logic [7:0]        infrared_tx_pulse_width;
  logic [RXFL_W-1:0] infrared_rx_filter_length;

  logic       wr_en;
  logic [7:0] idx;
  logic [7:0] wb;
  logic       hit;
  logic [1:0] mode_now;

  assign pready  = 1'b1;
  assign idx     = paddr[9:2];
  assign wb      = pwdata[7:0];
  assign wr_en   = psel && penable && pwrite && pstrb[0];
  assign mode_now = spi_master_mode ? spi_master_control[`UFC_MODE_HI:`UFC_MODE_LO]
                                    : frame_format_control[`UFC_MODE_HI:`UFC_MODE_LO];

  always_comb begin
    hit = 1'b1;
    case (idx)
      `UFC_IDX_FRAME, `UFC_IDX_BAUD_LO, `UFC_IDX_BAUD_HI, `UFC_IDX_ABWIN,
      `UFC_IDX_DBG, `UFC_IDX_INFRARED_EVENT_CONTROL, `UFC_IDX_TXPW, `UFC_IDX_RXFL,
      `UFC_IDX_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && (!hit || paddr[1:0] != 2'b00);

  // frame register: one address, two layouts selected by mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frame_format_control <= `UFC_FRAME_RST;
      spi_master_control   <= `UFC_SPI_RST;
    end else if (wr_en && !pslverr && idx == `UFC_IDX_FRAME) begin
      if (wb[`UFC_MODE_HI:`UFC_MODE_LO] == ufc_pkg::UFC_SPI_MASTER_MODE) begin   // [R2]
        spi_master_control <= wb & 8'hc6;                          // [R2]
        frame_format_control[`UFC_MODE_HI:`UFC_MODE_LO] <= wb[7:6];
      end else begin
        frame_format_control <= wb;
        spi_master_control   <= `UFC_SPI_RST;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bit_rate_divisor <= `UFC_BAUD_RST;
      baud_reload      <= 1'b0;
    end else begin
      baud_reload <= 1'b0;
      if (wr_en && !pslverr && idx == `UFC_IDX_BAUD_LO) begin
        bit_rate_divisor[7:0] <= wb;                                // [R9]
        baud_reload           <= 1'b1;                              // [R10]
      end
      if (wr_en && !pslverr && idx == `UFC_IDX_BAUD_HI) begin
        bit_rate_divisor[15:8] <= wb;                               // [R9]
        baud_reload            <= 1'b1;                             // [R10]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      autobaud_window_control   <= `UFC_BYTE_RST;
      debug_halt_control        <= `UFC_BYTE_RST;
      infrared_event_control    <= `UFC_BYTE_RST;
      infrared_tx_pulse_width   <= `UFC_BYTE_RST;
      infrared_rx_filter_length <= '0;
    end else if (wr_en && !pslverr) begin
      case (idx)
        `UFC_IDX_ABWIN:  autobaud_window_control   <= wb & 8'hc0;
        `UFC_IDX_DBG:    debug_halt_control        <= wb & 8'h01;
        `UFC_IDX_INFRARED_EVENT_CONTROL: infrared_event_control    <= wb & 8'h01;
        `UFC_IDX_TXPW:   infrared_tx_pulse_width   <= wb;
        `UFC_IDX_RXFL:   infrared_rx_filter_length <= wb[RXFL_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (idx)
      `UFC_IDX_FRAME:
        prdata[7:0] = spi_master_mode ? spi_master_control : frame_format_control;
      `UFC_IDX_BAUD_LO: prdata[7:0] = bit_rate_divisor[7:0];
      `UFC_IDX_BAUD_HI: prdata[7:0] = bit_rate_divisor[15:8];
      `UFC_IDX_ABWIN:   prdata[7:0] = autobaud_window_control;
      `UFC_IDX_DBG:     prdata[7:0] = debug_halt_control;
      `UFC_IDX_INFRARED_EVENT_CONTROL:  prdata[7:0] = infrared_event_control;
      `UFC_IDX_TXPW:    prdata[7:0] = infrared_tx_pulse_width;
      `UFC_IDX_RXFL:    prdata[RXFL_W-1:0] = infrared_rx_filter_length;
      `UFC_IDX_STATUS:
        prdata[3:0] = {autobaud_allowed, port_run, infrared_mode, parity_error_flag};
      default: prdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // frame format decode
  assign spi_master_mode = frame_format_control[`UFC_MODE_HI:`UFC_MODE_LO]
                           == ufc_pkg::UFC_SPI_MASTER_MODE;                    // [R1]
  assign infrared_mode   = mode_now == ufc_pkg::UFC_INFRARED_MODE;          // [R1]
  assign spi_lsb_first   = spi_master_mode && spi_master_control[`UFC_ORDER_BIT]; // [R7]
  assign spi_trailing    = spi_master_mode && spi_master_control[`UFC_PHASE_BIT]; // [R8]

  ufc_pkg::ufc_parity_t par_sel;
  assign par_sel   = ufc_pkg::ufc_parity_t'(frame_format_control[`UFC_PAR_HI:`UFC_PAR_LO]);
  // reserved code treated as disabled
  assign parity_en = !spi_master_mode &&
                     (par_sel == ufc_pkg::UFC_PAR_EVEN || par_sel == ufc_pkg::UFC_PAR_ODD); // [R3]

  logic [2:0] chw;
  assign chw = frame_format_control[`UFC_CHW_HI:`UFC_CHW_LO];

  always_comb begin
    data_bits = 4'd8;
    case (chw)
      3'd0:     data_bits = 4'd5;                                   // [R6]
      3'd1:     data_bits = 4'd6;
      3'd2:     data_bits = 4'd7;
      3'd3:     data_bits = 4'd8;
      3'd6,
      3'd7:     data_bits = 4'd9;
      default:  data_bits = 4'd8;                                   // reserved codes
    endcase
  end

  assign nine_bit_low_first  = !spi_master_mode && chw == 3'd6;     // [R6]
  assign nine_bit_high_first = !spi_master_mode && chw == 3'd7;     // [R6]
  assign tx_stop_bits = frame_format_control[`UFC_STOP_BIT] ? 2'd2 : 2'd1; // [R5]

  function automatic logic par_of(input logic [8:0] d, input logic [3:0] n,
                                  input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < n) p = p ^ d[i];
    end
    return p;
  endfunction

  assign tx_parity_bit = par_of(tx_data, data_bits, par_sel == ufc_pkg::UFC_PAR_ODD); // [R3]

  // set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      parity_error_flag <= 1'b0;
    end else if (rx_frame_done && port_run && parity_en && receiver_on &&
                 par_of(rx_data, data_bits, par_sel == ufc_pkg::UFC_PAR_ODD)
                 != rx_parity_bit) begin
      parity_error_flag <= 1'b1;                                    // [R4]
    end else if (parity_clear || !receiver_on) begin
      parity_error_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // auto-baud window and debug
  assign baud_divisor = bit_rate_divisor;
  assign sync_tol     = autobaud_window_control[7:6];               // [R11]
  assign autobaud_allowed = (rx_mode == ufc_pkg::UFC_RXM_GENERIC_AUTOBAUD ||
                             rx_mode == ufc_pkg::UFC_RXM_CONSTRAINED_AUTOBAUD) &&
                            mode_now == ufc_pkg::UFC_ASYNC && xck_is_input; // [R20]
  assign port_run = debug_halt_control[0] || !dbg_halted;           // [R12]

  ////////////////////////////////////////////////////////////////////////
  // infrared transmit pulse shaping; width must be set before tx enable
  logic [7:0]  pw_cnt;
  logic [19:0] thirds_len;
  logic [19:0] thirds_cnt;
  logic        pulse;

  // 3/16 of a baud period; divisor counts clocks per bit here
  assign thirds_len = 20'((32'(bit_rate_divisor) * `UFC_PW_NUM) / `UFC_PW_DEN);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pw_cnt     <= '0;
      thirds_cnt <= '0;
      pulse      <= 1'b0;
    end else if (!port_run || !transmitter_on) begin                 // [R17]
      pulse <= 1'b0;
    end else if (baud_tick) begin
      pulse      <= !tx_serial;                                     // [R15]
      pw_cnt     <= infrared_tx_pulse_width - 8'd1;
      thirds_cnt <= (thirds_len == '0) ? 20'd0 : thirds_len - 20'd1;
    end else if (pulse) begin
      if (infrared_tx_pulse_width == `UFC_TXPW_THIRDS) begin
        if (thirds_cnt == '0) pulse <= 1'b0;                        // [R14]
        else thirds_cnt <= thirds_cnt - 20'd1;
      end else begin
        if (pw_cnt == '0) pulse <= 1'b0;                            // [R15]
        else pw_cnt <= pw_cnt - 8'd1;
      end
    end
  end

  always_comb begin
    if (!infrared_mode || infrared_tx_pulse_width == `UFC_TXPW_BYPASS) begin
      ir_tx_out = tx_serial;                                        // [R16]
    end else begin
      ir_tx_out = !pulse;                                           // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // infrared receive source and filter; length set before rx enable
  logic rx_src;
  logic rx_filt;

  assign rx_src = (infrared_mode && infrared_event_control[0]) ? ir_event : rx_pin; // [R13]

  ufc_rx_filter #(
    .LEN_W (RXFL_W)
  ) u_filter (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .enable  (infrared_mode && port_run &&
              infrared_tx_pulse_width != `UFC_TXPW_BYPASS),        // [R19]
    .len     (infrared_rx_filter_length),
    .din     (rx_src),
    .dout    (rx_filt)
  );

  assign ir_rx_in = rx_filt;
endmodule

/* File: verif/ufc_far_node.sv */
`timescale 1ns/1ps
// remote node: both lines idle high; the one picked by on_event drops low for len clocks on request
module ufc_far_node (
  input  wire logic       sys_clk,  // clock
  input  wire logic       go,       // start a low pulse
  input  wire logic [7:0] len,      // pulse length in clocks
  input  wire logic       on_event, // pulse the event line, not the pin
  output logic            rx_pin,   // serial line to the port
  output logic            ir_event  // event line to the port
);
  logic [7:0] left;
  initial left = 8'h00;
  always @(posedge sys_clk) begin
    if (go) begin
      left <= len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // idle level is high, as on a pulled-up serial line
  assign rx_pin   = !((left != 8'h00) && !on_event);
  assign ir_event = !((left != 8'h00) && on_event);
endmodule

/* File: verif/ufc_frame_cfg_sva.sv */
`timescale 1ns/1ps
module ufc_frame_cfg_sva (
  input wire logic        sys_clk,           // clock
  input wire logic        rst_n,             // reset
  input wire logic        psel,              // select
  input wire logic        penable,           // access
  input wire logic        pwrite,            // direction
  input wire logic [11:0] paddr,             // address
  input wire logic [31:0] pwdata,            // write data
  input wire logic [3:0]  pstrb,             // strobes
  input wire logic        pslverr,           // error
  input wire logic        dbg_halted,        // cpu halted
  input wire logic        rx_frame_done,     // frame received
  input wire logic        parity_error_flag, // parity error
  input wire logic        parity_en,         // parity on
  input wire logic [1:0]  tx_stop_bits,      // stop bits
  input wire logic [3:0]  data_bits,         // width
  input wire logic        spi_master_mode,   // spi mode
  input wire logic        infrared_mode,     // ir mode
  input wire logic        spi_lsb_first,     // bit order
  input wire logic        spi_trailing,      // phase
  input wire logic [15:0] baud_divisor,      // divisor
  input wire logic        baud_reload,       // reload
  input wire logic        autobaud_allowed,  // autobaud usable
  input wire logic        port_run           // running
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  sequence acc_wr(a);
    psel && penable && pwrite && pstrb[0] && !pslverr && paddr == a;
  endsequence
  sequence frame_wr(m);
    acc_wr(12'h01c) ##0 m;
  endsequence
  sequence div_wr;
    psel && penable && pwrite && pstrb[0] && !pslverr && paddr[11:3] == 9'h004;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  mode_decode_a: assert property (frame_wr(1'h1) |=>
    spi_master_mode == ($past(pwdata[7:6]) == 2'h3) &&
    infrared_mode == ($past(pwdata[7:6]) == 2'h2)) else $error("mode decode wrong");
  frame_fields_a: assert property (frame_wr(pwdata[7:6] != 2'h3 && !pwdata[2]) |=>
    data_bits == 4'($past(pwdata[1:0])) + 4'h5 && parity_en == $past(pwdata[5]) &&
    tx_stop_bits == ($past(pwdata[3]) ? 2'h2 : 2'h1)) else $error("frame fields wrong");
  spi_layout_a: assert property (frame_wr(pwdata[7:6] == 2'h3) |=>
    spi_lsb_first == $past(pwdata[2]) && spi_trailing == $past(pwdata[1]))
    else $error("spi order or phase wrong");
  div_low_a: assert property (acc_wr(12'h020) |=> baud_divisor[7:0] == $past(pwdata[7:0])
    && $stable(baud_divisor[15:8])) else $error("divisor low byte wrong");
  reload_on_wr_a: assert property (div_wr |=> baud_reload)
    else $error("no reload after divisor write");
  reload_only_a: assert property (baud_reload |->
    $past(psel && penable && pwrite && pstrb[0] && !pslverr && paddr[11:3] == 9'h004))
    else $error("reload without divisor write");
  parity_error_flag_cause_a: assert property ($rose(parity_error_flag) |-> $past(rx_frame_done))
    else $error("parity error without frame");
  halt_ctl_a: assert property (acc_wr(12'h02c) |=>
    port_run == ($past(pwdata[0]) || !dbg_halted)) else $error("debug halt wrong");
  autobaud_mode_a: assert property (autobaud_allowed |-> !spi_master_mode && !infrared_mode)
    else $error("autobaud outside async");
endmodule

bind ufc_frame_cfg ufc_frame_cfg_sva u_sva (.sys_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pslverr, .dbg_halted, .rx_frame_done, .parity_error_flag,
  .parity_en, .tx_stop_bits, .data_bits, .spi_master_mode, .infrared_mode, .spi_lsb_first,
  .spi_trailing, .baud_divisor, .baud_reload, .autobaud_allowed, .port_run);

/* File: verif/usart_frame_baud_ir_config_tb_top.sv */
`timescale 1ns/1ps
module usart_frame_baud_ir_config_tb_top;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, dbg_halted;
  logic        transmitter_on, receiver_on, xck_is_input, baud_tick, tx_serial, rx_pin;
  logic        ir_event, rx_parity_bit, rx_frame_done, parity_clear, parity_error_flag;
  logic        tx_parity_bit, parity_en, nine_bit_low_first, nine_bit_high_first, go;
  logic        spi_master_mode, infrared_mode, spi_lsb_first, spi_trailing, on_event;
  logic        baud_reload, autobaud_allowed, port_run, ir_tx_out, ir_rx_in, er_v;
  logic [1:0]  rx_mode, tx_stop_bits, sync_tol;
  logic [3:0]  pstrb, data_bits;
  logic [7:0]  len;
  logic [8:0]  rx_data, tx_data;
  logic [11:0] paddr;
  logic [15:0] baud_divisor;
  logic [31:0] pwdata, prdata, rd_v;
  int          mismatches, cmp_count, rx_lo, tx_lo;

  ufc_frame_cfg DUT (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .dbg_halted, .transmitter_on, .receiver_on, .rx_mode,
    .xck_is_input, .baud_tick, .tx_serial, .rx_pin, .ir_event, .rx_data, .rx_parity_bit,
    .rx_frame_done, .parity_clear, .tx_data, .parity_error_flag, .tx_parity_bit, .parity_en,
    .tx_stop_bits, .data_bits, .nine_bit_low_first, .nine_bit_high_first, .spi_master_mode,
    .infrared_mode, .spi_lsb_first, .spi_trailing, .baud_divisor, .baud_reload, .sync_tol,
    .autobaud_allowed, .port_run, .ir_tx_out, .ir_rx_in);
  ufc_far_node far (.sys_clk, .go, .len, .on_event, .rx_pin, .ir_event);

  always #25 sys_clk = ~sys_clk;
  // low-time counters make the checks independent of output latency
  always @(posedge sys_clk) begin
    if (ir_rx_in === 1'h0) rx_lo++;
    if (ir_tx_out === 1'h0) tx_lo++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'h1);
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'h1, idx, {24'h00_0000, d});
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0000_0000);
    cmp(rd_v, exp);
  endtask
  task automatic rxf(input logic [8:0] d, input logic pb, input logic exp);
    @(posedge sys_clk);
    rx_data       <= d;
    rx_parity_bit <= pb;
    rx_frame_done <= 1'h1;
    @(posedge sys_clk);
    rx_frame_done <= 1'h0;
    @(negedge sys_clk);
    cmp(parity_error_flag, exp);
  endtask
  task automatic line_pulse(input logic ev, input logic [7:0] n, input int exp);
    @(negedge sys_clk);
    rx_lo = 0;
    @(posedge sys_clk);
    go <= 1'h1;
    len <= n;
    on_event <= ev;
    @(posedge sys_clk);
    go <= 1'h0;
    repeat (24) @(posedge sys_clk);
    cmp(rx_lo, exp);
  endtask
  task automatic tx_pulse(input int exp);
    @(negedge sys_clk);
    tx_lo = 0;
    @(posedge sys_clk);
    tx_serial <= 1'h0;
    baud_tick <= 1'h1;
    @(posedge sys_clk);
    baud_tick <= 1'h0;
    repeat (24) @(posedge sys_clk);
    cmp(tx_lo, exp);
    tx_serial <= 1'h1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(8'h07, 32'h0000_0003);
    for (int i = 8; i < 15; i++) rdc(i[7:0], 32'h0000_0000);
    apb(1'h0, 8'h0f, 32'h0000_0000);
    cmp(er_v, 1'h1);
    @(negedge sys_clk);
    cmp(data_bits, 4'h8);
    $display("test reset done");
  endtask
  task automatic t_frame;
    logic [7:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {2'(c % 3), c[1:0], c[0], c[2:0]};
      wr(8'h07, v);
      @(negedge sys_clk);
      cmp(infrared_mode, c % 3 == 2);
      cmp(spi_master_mode, 1'h0);
      cmp(parity_en, c[1]);
      cmp(tx_stop_bits, c[0] ? 2'h2 : 2'h1);
      cmp(data_bits, c < 4 ? c + 5 : (c < 6 ? 8 : 9));
      cmp({nine_bit_high_first, nine_bit_low_first}, c < 6 ? 0 : c - 5);
      rdc(8'h07, {24'h00_0000, v});
    end
    $display("test frame done");
  endtask
  task automatic t_spi;
    wr(8'h07, 8'hff);
    @(negedge sys_clk);
    cmp({spi_master_mode, spi_lsb_first, spi_trailing}, 3'h7);
    rdc(8'h07, 32'h0000_00c6);
    wr(8'h07, 8'hc2);
    @(negedge sys_clk);
    cmp({spi_lsb_first, spi_trailing}, 2'h1);
    wr(8'h07, 8'h03);
    rdc(8'h07, 32'h0000_0003);
    $display("test spi done");
  endtask
  task automatic t_baud;
    wr(8'h08, 8'h34);
    @(negedge sys_clk);
    cmp(baud_reload, 1'h1);
    wr(8'h09, 8'h12);
    @(negedge sys_clk);
    cmp(baud_divisor, 16'h1234);
    rdc(8'h09, 32'h0000_0012);
    $display("test baud done");
  endtask
  task automatic t_parity;
    wr(8'h07, 8'h23);
    @(posedge sys_clk);
    receiver_on <= 1'h1;
    tx_data <= 9'h007;
    @(negedge sys_clk);
    cmp(tx_parity_bit, 1'h1);
    rxf(9'h001, 1'h0, 1'h1);
    @(posedge sys_clk);
    parity_clear <= 1'h1;
    @(posedge sys_clk);
    parity_clear <= 1'h0;
    wr(8'h07, 8'h33);
    @(negedge sys_clk);
    cmp(tx_parity_bit, 1'h0);
    rxf(9'h001, 1'h0, 1'h0);
    $display("test parity done");
  endtask
  task automatic t_misc;
    for (int w = 0; w < 4; w++) begin
      wr(8'h0a, {w[1:0], 6'h00});
      @(negedge sys_clk);
      cmp(sync_tol, w);
    end
    @(posedge sys_clk);
    dbg_halted <= 1'h1;
    rx_mode <= 2'h2;
    xck_is_input <= 1'h1;
    wr(8'h0b, 8'h00);
    @(negedge sys_clk);
    cmp({port_run, autobaud_allowed}, 2'h1);
    wr(8'h0b, 8'h01);
    wr(8'h07, 8'h83);
    @(negedge sys_clk);
    cmp({port_run, autobaud_allowed}, 2'h2);
    $display("test debug done");
  endtask
  task automatic t_ir;
    @(posedge sys_clk);
    receiver_on <= 1'h0;
    transmitter_on <= 1'h0;
    wr(8'h0d, 8'hff);
    wr(8'h0e, 8'h00);
    @(posedge sys_clk);
    receiver_on <= 1'h1;
    tx_serial <= 1'h0;
    @(negedge sys_clk);
    cmp(ir_tx_out, 1'h0);
    line_pulse(1'h0, 8'h03, 3);
    wr(8'h0c, 8'h01);
    line_pulse(1'h0, 8'h04, 0);
    line_pulse(1'h1, 8'h04, 4);
    wr(8'h0c, 8'h00);
    wr(8'h0d, 8'h04);
    receiver_on <= 1'h0;
    wr(8'h0e, 8'h02);
    receiver_on <= 1'h1;
    line_pulse(1'h0, 8'h02, 0);
    line_pulse(1'h0, 8'h06, 6);
    wr(8'h08, 8'h20);
    wr(8'h09, 8'h00);
    @(posedge sys_clk);
    transmitter_on <= 1'h1;
    tx_pulse(4);
    wr(8'h0d, 8'h00);
    tx_pulse(6);
    $display("test infrared done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {sys_clk, rst_n, psel, penable, pwrite, dbg_halted, transmitter_on} = '0;
    {receiver_on, xck_is_input, baud_tick, rx_parity_bit, rx_frame_done} = '0;
    {parity_clear, go, on_event, rx_mode, len, rx_data, tx_data, paddr, pwdata} = '0;
    {mismatches, cmp_count, rx_lo, tx_lo} = '0;
    tx_serial = 1'h1;
    pstrb = 4'hf;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_reset;
    t_frame;
    t_spi;
    t_baud;
    t_parity;
    t_misc;
    t_ir;
    final_report;
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    mismatches++;
    final_report;
  end
endmodule
